// *** design/card_params.svh ***
// Offsets, field positions, reset values and timing counts of the card link
`ifndef CARD_PARAMS_SVH
`define CARD_PARAMS_SVH

// Attribute-space offsets of the configuration registers
`define OFS_OPTION 11'h200
`define OFS_STATUS 11'h202
`define OFS_PINREP 11'h204
`define OFS_SOCKET 11'h206

// Reset values
`define RST_STATUS 8'h00
`define RST_PINREP 8'h0c
`define RST_SOCKET 8'h00

// Card status fields
`define ST_CHANGED 7
`define ST_CHANGE_SIGNAL_ENABLE 6
`define ST_BYTEIO 5
`define ST_PWRDN 2
`define ST_INT 1

// Pin replacement fields; masks share the live bit positions on write
`define PR_RDYFLAG 5
`define PR_WPFLAG 4
`define PR_RDYLIVE 1
`define PR_WPLIVE 0
`define PR_ONES 8'h0c

// Socket and copy fields
`define SC_DRIVE 4

// Host register map, byte addresses
`define HOST_CMD 4'h0
`define HOST_WDATA 4'h4
`define HOST_RDATA 4'h8
`define HOST_STATUS 4'hc

// Host command word fields
`define CMD_KIND_LO 11
`define CMD_LOWEN 13
`define CMD_HIGHEN 14

// Strobe timing, host side
`define CLK_NS 100
`define T_SETUP_NS 200
`define T_STROBE_NS 600
`define T_HOLD_NS 400
`define T_RECOVER_NS 200
`define T_SETUP_CYC ((`T_SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define T_STROBE_CYC ((`T_STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define T_HOLD_CYC ((`T_HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define T_RECOVER_CYC ((`T_RECOVER_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// *** design/card_pkg.sv ***
// Types shared by the card end and the socket end
package card_pkg;

    // Host-side strobe bundle, all active low
    typedef struct packed {
        logic regN;
        logic ceLowN;
        logic ceHighN;
        logic oeN;
        logic weN;
        logic ioRdN;
        logic ioWrN;
    } strobe_type;

    // Card end state
    typedef struct packed {
        strobe_type s1;
        strobe_type s2;
        strobe_type s3;
        logic [10:0] a1;
        logic [10:0] a2;
        logic [15:0] d1;
        logic [15:0] d2;
        strobe_type capS;
        logic [10:0] capA;
        logic [15:0] capD;
        logic change_signal_enable;
        logic byteIo;
        logic power_save_request;
        logic rdyFlag;
        logic wpFlag;
        logic drive;
        logic rdyPrev;
        logic busy;
        logic [15:0] rdData;
        logic rdLowEn;
        logic rdHighEn;
        logic ioWrStb;
        logic ioRdStb;
        logic [15:0] ioWrData;
        logic [1:0] ioBe;
        logic [10:0] ioA;
    } card_state_type;

    // Transfer kinds of the socket end
    typedef enum logic [1:0] {
        KIND_ATTR_RD = 2'h0,
        KIND_ATTR_WR = 2'h1,
        KIND_IO_RD = 2'h2,
        KIND_IO_WR = 2'h3
    } kind_type;

    // Socket sequencer states
    typedef enum logic [4:0] {
        H_IDLE = 5'h01,
        H_SETUP = 5'h02,
        H_STROBE = 5'h04,
        H_HOLD = 5'h08,
        H_RECOVER = 5'h10
    } host_fsm_type;

    // Socket end state
    typedef struct packed {
        host_fsm_type fsm;
        logic [3:0] cnt;
        logic [15:0] cmd;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic rdAck;
        logic [31:0] avsData;
    } host_state_type;

endpackage

// *** design/card_bus_if.sv ***
// Socket wires between host controller and card
`timescale 1ns/1ns
interface card_bus_if;
    logic regN; // Register select, low
    logic lowByteEnableN; // Low byte enable
    logic highByteEnableN; // High byte enable
    logic oeN; // Output enable
    logic weN; // Write enable
    logic ioReadN; // I/O read strobe
    logic ioWriteN; // I/O write strobe
    logic [10:0] addr; // Address
    logic [15:0] hostData; // Host data out
    logic hostDataEn; // Host drives data
    logic [15:0] cardData; // Card data out
    logic cardDataLowEn; // Card drives D7-D0
    logic cardDataHighEn; // Card drives D15-D8
    logic statusChangeN; // Status change, low
    logic widePortN; // 16-bit port, low
    logic readyIrq; // Ready or interrupt level
    logic [15:0] busData; // Resolved data lines

    // Undriven lanes read as zero
    assign busData[7:0] = hostDataEn ? hostData[7:0] :
        (cardDataLowEn ? cardData[7:0] : 8'h00);
    assign busData[15:8] = hostDataEn ? hostData[15:8] :
        (cardDataHighEn ? cardData[15:8] : 8'h00);

    modport host (
        output regN, lowByteEnableN, highByteEnableN, oeN, weN, ioReadN, ioWriteN,
        output addr, hostData, hostDataEn,
        input busData, statusChangeN, widePortN, readyIrq
    );
    modport card (
        input regN, lowByteEnableN, highByteEnableN, oeN, weN, ioReadN, ioWriteN,
        input addr, busData,
        output cardData, cardDataLowEn, cardDataHighEn, statusChangeN, widePortN, readyIrq
    );
endinterface

// *** design/card_config_status_regs.sv ***
// Card end: configuration and status registers and I/O byte lanes
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ns
`include "card_params.svh"

// Functional notes
// - Changed bit ORs both change flags
// - Changed, enable, I/O mode drive status low
// - Enable zero in I/O mode holds status high
// - Byte I/O bit stored, has no effect
// - Power-down bit selects power saving state
// - Power bit change forces busy until entered
// - Interrupt bit follows internal request unless disabled
// - Interrupt disable forces interrupt bit zero
// - Status resets zero, fixed zeros, read-only bits
// - Live bit change sets its change flag
// - Live ready shows ready, interrupt in I/O
// - Live write-protect always reads zero
// - Mask bit gates host write of flag
// - Pin register resets 0Ch, fixed bits, masks
// - Socket register holds drive bit, rest zero
// - Host writes socket before option register
// - Attribute space even byte only, low lane
// - Registers at 200h, none in True IDE
// - Read needs select and OE; INFO_STRUCTURE write ignored
// - Host negates enable or strobes between cycles
// - Wide-port asserted for every I/O address
// - I/O byte lanes follow the enables
// - Index 1 to 3 means I/O mode
module card_config_status_regs
    import card_pkg::*;
(
    input wire logic ref_clk, // Card clock
    input wire logic sys_rst, // Async reset, high
    card_bus_if.card bus, // Socket wires
    input wire logic [5:0] cfgIndex, // Configuration index
    input wire logic trueIdeMode, // True IDE strap, level
    input wire logic cardReady, // Internal ready
    input wire logic irqRequest, // Internal interrupt request
    input wire logic irqDisableCtl, // Interrupt disable control
    input wire logic powerStateEntered, // Actual power state, 1 saving
    output logic powerSaveRequest, // Requested power saving
    output logic driveNumber, // Drive select bit
    output logic [10:0] ioAddr, // I/O address
    output logic [1:0] ioByteEn, // I/O byte lanes, bit1 odd
    output logic [15:0] ioWriteData, // I/O write data
    output logic ioWriteStrobe, // I/O write pulse
    output logic ioReadStrobe, // I/O read start pulse
    input wire logic [15:0] ioReadData // I/O read data, odd in top
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Lane mask for an I/O access; bit0 even byte, bit1 odd byte
    function automatic logic [1:0] laneMask(input logic ceLowN, input logic ceHighN,
                                             input logic a0);
        logic [1:0] m;
        m = 2'h0;
        if (!ceLowN && !ceHighN)
        begin
            m = 2'h3; // Full word
        end
        else if (!ceLowN)
        begin
            m = a0 ? 2'h2 : 2'h1; // Single byte on low lane
        end
        else if (!ceHighN)
        begin
            m = 2'h2; // Odd byte on high lane
        end
        return m;
    endfunction

    // Attribute access legal: even byte, register select, not IDE
    function automatic logic attrOk(input strobe_type s, input logic [10:0] a,
                                    input logic ide);
        return !s.regN && !s.ceLowN && !a[0] && !ide;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State and derived levels

    localparam logic [7:0] statusRst = `RST_STATUS;
    localparam logic [7:0] pinRst = `RST_PINREP;
    localparam logic [7:0] socketRst = `RST_SOCKET;

    card_state_type q; // Registered state
    card_state_type d; // Next state
    strobe_type inS; // Raw strobes
    logic ioMode; // Card configured for I/O
    logic liveRdy; // Live ready bit
    logic liveWp; // Live write-protect bit
    logic intBit; // Interrupt status bit
    logic changed; // Change summary
    logic [7:0] statusRd; // Status read value
    logic [7:0] pinRd; // Pin replacement read value
    logic [7:0] socketRd; // Socket read value

    assign inS = '{regN: bus.regN, ceLowN: bus.lowByteEnableN,
                   ceHighN: bus.highByteEnableN, oeN: bus.oeN, weN: bus.weN,
                   ioRdN: bus.ioReadN, ioWrN: bus.ioWriteN};

    assign ioMode = (cfgIndex == 6'h01) || (cfgIndex == 6'h02) || (cfgIndex == 6'h03);
    assign liveRdy = ioMode ? irqRequest : (cardReady && !q.busy);
    assign liveWp = 1'b0; // No switch on this card
    assign intBit = irqRequest && !irqDisableCtl;
    assign changed = q.rdyFlag || q.wpFlag;

    // Read images; unlisted bits read zero, except pin register bits 3 and 2, which read one
    always_comb
    begin
        statusRd = 8'h00;
        statusRd[`ST_CHANGED] = changed;
        statusRd[`ST_CHANGE_SIGNAL_ENABLE] = q.change_signal_enable;
        statusRd[`ST_BYTEIO] = q.byteIo;
        statusRd[`ST_PWRDN] = q.power_save_request;
        statusRd[`ST_INT] = intBit;
        pinRd = `PR_ONES;
        pinRd[`PR_RDYFLAG] = q.rdyFlag;
        pinRd[`PR_WPFLAG] = q.wpFlag;
        pinRd[`PR_RDYLIVE] = liveRdy;
        pinRd[`PR_WPLIVE] = liveWp;
        socketRd = 8'h00;
        socketRd[`SC_DRIVE] = q.drive;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb
    begin
        d = q;
        // Two-stage synchroniser, then one delay stage for edges
        d.s1 = inS;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.a1 = bus.addr;
        d.a2 = q.a1;
        d.d1 = bus.busData;
        d.d2 = q.d1;
        d.ioWrStb = 1'b0;
        d.ioRdStb = 1'b0;
        d.rdLowEn = 1'b0;
        d.rdHighEn = 1'b0;

        // Capture address and data while a write strobe is low
        if (!q.s2.weN || !q.s2.ioWrN)
        begin
            d.capS = q.s2;
            d.capA = q.a2;
            d.capD = q.d2;
        end

        // Attribute write commits on the trailing edge of write enable
        if (!q.s3.weN && q.s2.weN && attrOk(q.capS, q.capA, trueIdeMode)
            && (q.capA[10:9] == 2'h1)) // Info structure writes below 200h excluded here
        begin
            unique case (q.capA)
                `OFS_STATUS:
                begin
                    // Changed and interrupt positions ignored
                    d.change_signal_enable = q.capD[`ST_CHANGE_SIGNAL_ENABLE];
                    d.byteIo = q.capD[`ST_BYTEIO];
                    d.power_save_request = q.capD[`ST_PWRDN];
                end
                `OFS_PINREP:
                begin
                    if (q.capD[`PR_RDYLIVE])
                    begin
                        d.rdyFlag = q.capD[`PR_RDYFLAG];
                    end
                    if (q.capD[`PR_WPLIVE])
                    begin
                        d.wpFlag = q.capD[`PR_WPFLAG];
                    end
                end
                `OFS_SOCKET:
                begin
                    d.drive = q.capD[`SC_DRIVE]; // Socket bits dropped
                end
                default:
                begin
                    // Option register and reserved space live elsewhere
                end
            endcase
        end

        // Hardware set after host write, so the set wins
        d.rdyPrev = liveRdy;
        if (liveRdy != q.rdyPrev)
        begin
            d.rdyFlag = 1'b1;
        end
        // Live write-protect is constant, so its flag never sets here

        // Busy on power bit change, cleared once the state is reached
        if (d.power_save_request != q.power_save_request)
        begin
            d.busy = 1'b1;
        end
        else if (powerStateEntered == q.power_save_request)
        begin
            d.busy = 1'b0;
        end

        // Attribute read while select and output enable are low
        if (!q.s2.oeN && q.s2.weN && attrOk(q.s2, q.a2, trueIdeMode))
        begin
            d.rdLowEn = 1'b1; // Upper lane left undriven
            unique case (q.a2)
                `OFS_STATUS: d.rdData = {8'h00, statusRd};
                `OFS_PINREP: d.rdData = {8'h00, pinRd};
                `OFS_SOCKET: d.rdData = {8'h00, socketRd};
                default: d.rdData = 16'h0000; // Unmapped reads zero
            endcase
        end

        // I/O only with register select low and card in I/O mode
        if (ioMode && !q.s2.regN && !trueIdeMode)
        begin
            if (!q.s2.ioRdN)
            begin
                d.ioRdStb = q.s3.ioRdN; // Leading edge pulse
                d.ioA = q.a2;
                d.ioBe = laneMask(q.s2.ceLowN, q.s2.ceHighN, q.a2[0]);
                unique case (laneMask(q.s2.ceLowN, q.s2.ceHighN, q.a2[0]))
                    2'h3:
                    begin
                        d.rdData = ioReadData;
                        d.rdLowEn = 1'b1;
                        d.rdHighEn = 1'b1;
                    end
                    2'h2:
                    begin
                        // Odd byte: low lane if only low enable
                        d.rdData = {ioReadData[15:8], ioReadData[15:8]};
                        d.rdLowEn = !q.s2.ceLowN;
                        d.rdHighEn = q.s2.ceLowN;
                    end
                    2'h1:
                    begin
                        d.rdData = {8'h00, ioReadData[7:0]};
                        d.rdLowEn = 1'b1;
                    end
                    default: d.rdData = q.rdData;
                endcase
            end
        end

        // I/O write commits on trailing edge of the write strobe
        if (ioMode && !q.capS.regN && !trueIdeMode && !q.s3.ioWrN && q.s2.ioWrN)
        begin
            d.ioWrStb = 1'b1;
            d.ioA = q.capA;
            d.ioBe = laneMask(q.capS.ceLowN, q.capS.ceHighN, q.capA[0]);
            if (!q.capS.ceLowN && q.capS.ceHighN)
            begin
                d.ioWrData = {q.capD[7:0], q.capD[7:0]}; // Byte from low lane
            end
            else
            begin
                d.ioWrData = q.capD; // Word or odd byte on high lane
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            q <= '0;
            q.s1 <= '1;
            q.s2 <= '1;
            q.s3 <= '1;
            q.capS <= '1;
            q.change_signal_enable <= statusRst[`ST_CHANGE_SIGNAL_ENABLE];
            q.byteIo <= statusRst[`ST_BYTEIO];
            q.power_save_request <= statusRst[`ST_PWRDN];
            q.rdyFlag <= pinRst[`PR_RDYFLAG];
            q.wpFlag <= pinRst[`PR_WPFLAG];
            q.drive <= socketRst[`SC_DRIVE];
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Status pin only meaningful in I/O mode; idle high otherwise
    assign bus.statusChangeN = !(ioMode && changed && q.change_signal_enable);
    // Every addressed I/O location takes both widths
    assign bus.widePortN = !(ioMode && !q.s2.regN && !trueIdeMode
                             && (!q.s2.ceLowN || !q.s2.ceHighN));
    assign bus.readyIrq = liveRdy;
    assign bus.cardData = q.rdData;
    assign bus.cardDataLowEn = q.rdLowEn;
    assign bus.cardDataHighEn = q.rdHighEn;
    assign powerSaveRequest = q.power_save_request;
    assign driveNumber = q.drive;
    assign ioAddr = q.ioA;
    assign ioByteEn = q.ioBe;
    assign ioWriteData = q.ioWrData;
    assign ioWriteStrobe = q.ioWrStb;
    assign ioReadStrobe = q.ioRdStb;

endmodule

// *** design/card_socket_host.sv ***
// Socket end: Avalon-MM command registers driving card strobes
`timescale 1ns/1ns
`include "card_params.svh"
module card_socket_host
    import card_pkg::*;
(
    input wire logic ref_clk, // Host clock
    input wire logic sys_rst, // Async reset, high
    card_bus_if.host bus, // Socket wires
    input wire logic [3:0] avsAddress, // Byte address
    input wire logic avsRead, // Read request
    input wire logic avsWrite, // Write request
    input wire logic [31:0] avsWriteData, // Write data
    output logic [31:0] avsReadData, // Read data
    output logic avsWaitRequest // Stall
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers and state

    localparam logic [3:0] setupCyc = 4'(`T_SETUP_CYC);
    localparam logic [3:0] strobeCyc = 4'(`T_STROBE_CYC);
    localparam logic [3:0] holdCyc = 4'(`T_HOLD_CYC);
    localparam logic [3:0] recoverCyc = 4'(`T_RECOVER_CYC);

    // True for writes that carry host data
    function automatic logic isWrite(input logic [15:0] c);
        return c[`CMD_KIND_LO];
    endfunction

    host_state_type q; // Registered state
    host_state_type d; // Next state
    kind_type kind; // Current transfer kind
    logic busy; // Sequencer active
    logic cmdStall; // Command write must wait

    assign kind = kind_type'(q.cmd[`CMD_KIND_LO+1:`CMD_KIND_LO]);
    assign busy = (q.fsm != H_IDLE);
    assign cmdStall = avsWrite && (avsAddress == `HOST_CMD) && busy;
    // Reads wait one cycle for the registered data
    assign avsWaitRequest = (avsRead && !q.rdAck) || cmdStall;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb
    begin
        d = q;
        d.rdAck = avsRead && !q.rdAck;
        if (avsRead && !q.rdAck)
        begin
            unique case (avsAddress)
                `HOST_CMD: d.avsData = {16'h0000, q.cmd};
                `HOST_WDATA: d.avsData = {16'h0000, q.wdata};
                `HOST_RDATA: d.avsData = {16'h0000, q.rdata};
                `HOST_STATUS: d.avsData = {28'h0000000, bus.readyIrq, bus.widePortN,
                                           bus.statusChangeN, busy};
                default: d.avsData = 32'h00000000; // Unmapped
            endcase
        end
        if (avsWrite && !cmdStall && (avsAddress == `HOST_WDATA))
        begin
            d.wdata = avsWriteData[15:0];
        end
        if (d.cnt != 4'h0)
        begin
            d.cnt = q.cnt - 4'h1;
        end
        unique case (q.fsm)
            H_IDLE:
            begin
                if (avsWrite && (avsAddress == `HOST_CMD))
                begin
                    d.cmd = avsWriteData[15:0];
                    d.fsm = H_SETUP;
                    d.cnt = setupCyc;
                end
            end
            H_SETUP:
            begin
                if (q.cnt == 4'h1)
                begin
                    d.fsm = H_STROBE;
                    d.cnt = strobeCyc;
                end
            end
            H_STROBE:
            begin
                if (q.cnt == 4'h1)
                begin
                    d.rdata = bus.busData; // Sample at strobe end
                    d.fsm = H_HOLD;
                    d.cnt = holdCyc;
                end
            end
            H_HOLD:
            begin
                // Address and data held while card sees trailing edge
                if (q.cnt == 4'h1)
                begin
                    d.fsm = H_RECOVER;
                    d.cnt = recoverCyc;
                end
            end
            H_RECOVER:
            begin
                // Enables negated between cycles
                if (q.cnt == 4'h1)
                begin
                    d.fsm = H_IDLE;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            q <= '0;
            q.fsm <= H_IDLE;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Socket wires

    assign bus.regN = !(busy && (q.fsm != H_RECOVER));
    assign bus.lowByteEnableN = !(busy && (q.fsm != H_RECOVER) && q.cmd[`CMD_LOWEN]);
    assign bus.highByteEnableN = !(busy && (q.fsm != H_RECOVER) && q.cmd[`CMD_HIGHEN]);
    assign bus.oeN = !((q.fsm == H_STROBE) && (kind == KIND_ATTR_RD));
    assign bus.weN = !((q.fsm == H_STROBE) && (kind == KIND_ATTR_WR));
    assign bus.ioReadN = !((q.fsm == H_STROBE) && (kind == KIND_IO_RD));
    assign bus.ioWriteN = !((q.fsm == H_STROBE) && (kind == KIND_IO_WR));
    assign bus.addr = q.cmd[10:0];
    assign bus.hostData = q.wdata;
    assign bus.hostDataEn = busy && (q.fsm != H_RECOVER) && isWrite(q.cmd);
    assign avsReadData = q.avsData;

endmodule

// *** test/card_config_status_regs_chk.sv ***
// Socket wire assertions for the card link
`timescale 1ns/1ns
module card_config_status_regs_chk (
    input logic ref_clk, // Clock
    input logic sys_rst, // Reset
    input logic regN, // Select
    input logic oeN, // Read enable
    input logic ioReadN, // I/O read
    input logic ioWriteN, // I/O write
    input logic hostDataEn, // Host drives
    input logic cardDataLowEn, // Low lane
    input logic cardDataHighEn, // High lane
    input logic statusChangeN, // Change out
    input logic widePortN, // Wide port
    input logic readyIrq, // Live ready
    input logic [5:0] cfgIndex, // Mode index
    input logic irqRequest // Interrupt
);
    logic [5:0] hist; // Recent idle strobes
    logic ioMode; // Index 1 to 3
    assign ioMode = cfgIndex inside {[6'h1:6'h3]};
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // Six quiet cycles mean the card synchronisers are quiet too
    always_ff @(posedge ref_clk or posedge sys_rst)
        if (sys_rst)
            hist <= 6'h3f;
        else
            hist <= {hist[4:0], oeN & ioReadN & ioWriteN};
    a_no_fight: assert property (hostDataEn |-> !cardDataLowEn && !cardDataHighEn)
        else $error("card lane on during host drive");
    a_lane_cause: assert property (cardDataLowEn || cardDataHighEn |-> !(&hist))
        else $error("card lane on without strobe");
    a_high_io: assert property (cardDataHighEn |-> ioMode)
        else $error("high lane outside I/O mode");
    a_wide_idle: assert property (regN [*3] |-> widePortN)
        else $error("wide port low while idle");
    a_wide_io: assert property (ioMode && !regN && !(ioReadN && ioWriteN) [*4] |-> !widePortN)
        else $error("wide port missing on I/O");
    a_sts_mem: assert property (cfgIndex == 6'h0 |-> statusChangeN)
        else $error("status change low in memory mode");
    a_sts_falls: assert property ($fell(statusChangeN) |-> ioMode)
        else $error("status change fell outside I/O");
    a_ready_irq: assert property (ioMode |-> readyIrq == irqRequest)
        else $error("live ready not interrupt in I/O");
endmodule

// *** test/test_card_config_status_regs.sv ***
// Bench joining socket end and card end
`timescale 1ns/1ns
`include "card_params.svh"
module test_card_config_status_regs;
    import card_pkg::*;
    logic ref_clk = 0, sys_rst = 1, cardReady = 0, irqRequest = 0, irqDisableCtl = 0, ioReadStrobe;
    logic powerSaveRequest, driveNumber, ioWriteStrobe, avsRead = 0, avsWrite = 0, avsWaitRequest;
    logic [3:0] pse = 0, avsAddress = 0;
    logic [5:0] cfgIndex = 0;
    logic [10:0] ioAddr;
    logic [1:0] ioByteEn;
    logic [15:0] ioWriteData, ioReadData = 0, w, r;
    logic [31:0] avsWriteData = 0, avsReadData, s, rdQ[$], ioQ[$];
    int errors = 0, check_count = 0, cyc = 0;
    card_bus_if bus();
    card_config_status_regs card_config_status_regs_inst (.ref_clk, .sys_rst, .bus, .cfgIndex,
        .trueIdeMode(1'b0), .cardReady, .irqRequest, .irqDisableCtl, .powerStateEntered(pse[3]),
        .powerSaveRequest, .driveNumber, .ioAddr, .ioByteEn, .ioWriteData, .ioWriteStrobe,
        .ioReadStrobe, .ioReadData);
    card_socket_host card_socket_host_inst (.ref_clk, .sys_rst, .bus, .avsAddress, .avsRead,
        .avsWrite, .avsWriteData, .avsReadData, .avsWaitRequest);
    card_config_status_regs_chk chk_inst (.ref_clk, .sys_rst, .regN(bus.regN), .oeN(bus.oeN),
        .ioReadN(bus.ioReadN), .ioWriteN(bus.ioWriteN), .hostDataEn(bus.hostDataEn),
        .cardDataLowEn(bus.cardDataLowEn), .cardDataHighEn(bus.cardDataHighEn),
        .statusChangeN(bus.statusChangeN), .widePortN(bus.widePortN),
        .readyIrq(bus.readyIrq), .cfgIndex, .irqRequest);
    initial forever #50 ref_clk = ~ref_clk;
    // Power state lags the request so busy is seen
    always @(posedge ref_clk) pse <= {pse[2:0], powerSaveRequest};
    // Cut a hang short
    always @(posedge ref_clk)
    begin
        if (++cyc == 8000)
        begin
            errors++;
            tally_and_finish;
        end
    end
    task tally_and_finish;
        errors += rdQ.size() + ioQ.size();
        $display("errors %0d check_count %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, e);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Result watcher, oldest note first
    always @(negedge ref_clk)
    begin
        if (avsRead && !avsWaitRequest && avsAddress == `HOST_RDATA)
            chk(avsReadData, rdQ.pop_front());
        if (ioWriteStrobe)
            chk({ioAddr, ioByteEn, ioWriteData}, ioQ.pop_front());
        if (ioReadStrobe) chk(ioAddr >> 1, 8);
    end
    // One Avalon transfer; held until waitrequest is seen low
    task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWriteData <= d;
        @(posedge ref_clk);
        while (avsWaitRequest)
            @(posedge ref_clk);
        s = avsReadData;
        avsWrite <= 0;
        avsRead <= 0;
        @(posedge ref_clk);
    endtask
    // Socket transfer: data, command, wait idle, fetch read data
    task acc(input kind_type k, input logic [10:0] a, input logic [1:0] ln, input logic [15:0] d, e);
        av(1, `HOST_WDATA, {16'h0, d});
        av(1, `HOST_CMD, {17'h0, ln, k, a});
        s = 1;
        while (s[0])
            av(0, `HOST_STATUS, 0);
        if (!k[0])
        begin
            rdQ.push_back({16'h0, e});
            av(0, `HOST_RDATA, 0);
        end
    endtask
    task ar(input logic [10:0] a, input logic [7:0] e);
        acc(KIND_ATTR_RD, a, 2'b11, 0, {8'h0, e});
    endtask
    task aw(input logic [10:0] a, input logic [7:0] d);
        acc(KIND_ATTR_WR, a, 2'b01, {8'h0, d}, 0);
    endtask
    task pins(input logic [2:0] e);
        av(0, `HOST_STATUS, 0);
        chk(s[3:1], e);
    endtask
    initial
    begin
        void'($urandom(86987));
        repeat (2) @(posedge ref_clk);
        sys_rst <= 0;
        ar(11'h202, 8'h00);
        ar(11'h204, 8'h0c);
        ar(11'h206, 8'h00);
        aw(11'h206, 8'hff);
        aw(11'h006, 8'h00);
        aw(11'h207, 8'h00);
        ar(11'h206, 8'h10);
        chk(driveNumber, 1);
        aw(11'h202, 8'hff);
        ar(11'h202, 8'h64);
        chk(powerSaveRequest, 1);
        irqRequest <= 1;
        aw(11'h202, 8'h40);
        ar(11'h202, 8'h42);
        chk(powerSaveRequest, 0);
        irqDisableCtl <= 1;
        cardReady <= 1;
        ar(11'h202, 8'hc0);
        ar(11'h204, 8'h2e);
        aw(11'h204, 8'h02);
        ar(11'h204, 8'h0e);
        aw(11'h202, 8'h44);
        ar(11'h204, 8'h2e);
        aw(11'h204, 8'h30);
        aw(11'h204, 8'h11);
        ar(11'h204, 8'h3e);
        irqRequest <= 0;
        cfgIndex <= 6'h1 + 6'($urandom % 3);
        pins(3'b010);
        irqRequest <= 1;
        pins(3'b110);
        aw(11'h202, 8'h04);
        pins(3'b111);
        w = 16'($urandom);
        r = 16'($urandom);
        ioReadData <= r;
        ioQ.push_back({11'h010, 2'b11, w});
        acc(KIND_IO_WR, 11'h010, 2'b11, w, 0);
        ioQ.push_back({11'h011, 2'b10, w[7:0], w[7:0]});
        acc(KIND_IO_WR, 11'h011, 2'b01, w, 0);
        acc(KIND_IO_RD, 11'h010, 2'b11, 0, r);
        acc(KIND_IO_RD, 11'h011, 2'b01, 0, {8'h0, r[15:8]});
        acc(KIND_IO_RD, 11'h010, 2'b10, 0, {r[15:8], 8'h0});
        tally_and_finish;
    end
endmodule
